// *** pkg/config_regs_pkg.sv ***
// register map, field layout and timing constants for the brownout / noise gate bank
package config_regs_pkg;
	// ----------------------------------------------------------------
	// offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_BROWNOUT_ATTACK_HOLD = 8'h20;
	localparam logic [7:0] ADDR_SUPPLY_SWITCH_LOW_THRESHOLD = 8'h34;
	localparam logic [7:0] ADDR_NOISE_GATE_CONTROL = 8'h35;
	localparam logic [7:0] ADDR_NOISE_GATE_RAMP_SWITCH_HYSTERESIS = 8'h36;
	localparam logic [7:0] ADDR_SUPPLY_SWITCH_THRESHOLD = 8'h37;
	localparam logic [7:0] ADDR_PIN_PULLDOWN_ENABLES = 8'h38;
	localparam logic [7:0] ADDR_INTERRUPT_MASK_BROWNOUT = 8'h3B;
	localparam logic [7:0] ADDR_INTERRUPT_MASK_CHECKSUM_LIMITER = 8'h3C;
	localparam logic [7:0] ADDR_BROWNOUT_CONTROL = 8'h1F;
	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_BROWNOUT_ATTACK_HOLD = 8'h2E;
	localparam logic [7:0] RST_SUPPLY_SWITCH_LOW_THRESHOLD = 8'h06;
	localparam logic [7:0] RST_NOISE_GATE_CONTROL = 8'hBD;
	localparam logic [7:0] RST_NOISE_GATE_RAMP_SWITCH_HYSTERESIS = 8'hAD;
	localparam logic [7:0] RST_SUPPLY_SWITCH_THRESHOLD = 8'hA8;
	localparam logic [7:0] RST_PIN_PULLDOWN_ENABLES = 8'h00;
	localparam logic [7:0] RST_INTERRUPT_MASK_BROWNOUT = 8'hFC;
	localparam logic [7:0] RST_INTERRUPT_MASK_CHECKSUM_LIMITER = 8'hBB;
	localparam logic [7:0] RST_BROWNOUT_CONTROL = 8'h00;
	// ----------------------------------------------------------------
	// writable bit masks (others are read-only and hold reset value)
	// ----------------------------------------------------------------
	localparam logic [7:0] WMASK_BROWNOUT_ATTACK_HOLD = 8'hFF;
	localparam logic [7:0] WMASK_SUPPLY_SWITCH_LOW_THRESHOLD = 8'h06;
	localparam logic [7:0] WMASK_NOISE_GATE_CONTROL = 8'hFC;
	localparam logic [7:0] WMASK_NOISE_GATE_RAMP_SWITCH_HYSTERESIS = 8'hEF;
	localparam logic [7:0] WMASK_SUPPLY_SWITCH_THRESHOLD = 8'h9F;
	localparam logic [7:0] WMASK_PIN_PULLDOWN_ENABLES = 8'h7C;
	localparam logic [7:0] WMASK_INTERRUPT_MASK_BROWNOUT = 8'hC0;
	localparam logic [7:0] WMASK_INTERRUPT_MASK_CHECKSUM_LIMITER = 8'h41;
	localparam logic [7:0] WMASK_BROWNOUT_CONTROL = 8'h03;
	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int ATTACK_RATE_LSB = 5;
	localparam int ATTACK_STEP_LSB = 3;
	localparam int HOLD_TIME_LSB = 0;
	localparam int LOW_THRESHOLD_LSB = 1;
	localparam int GATE_TIMER_LSB = 5;
	localparam int GATE_LEVEL_LSB = 3;
	localparam int GATE_ENABLE_BIT = 2;
	localparam int GATE_RAMP_BIT = 5;
	localparam int HYSTERESIS_LSB = 0;
	localparam int DETECT_MODE_BIT = 7;
	localparam int SWITCH_THRESHOLD_LSB = 0;
	localparam int PULLDOWN_LSB = 2;
	localparam int MASK_MUTE_BIT = 7;
	localparam int MASK_INF_HOLD_BIT = 6;
	localparam int MASK_CHECKSUM_BIT = 6;
	localparam int MASK_LIMITER_BIT = 0;
	localparam int HOLD_CLEAR_BIT = 0;
	localparam int INF_HOLD_BIT = 1;
	localparam logic [3:0] HYSTERESIS_FIRST_VALID = 4'hA;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLOCK_HZ = 50000000;
	localparam int HOLD_MS_UNIT = 1;
	localparam int CYCLES_PER_MS = CLOCK_HZ / 1000 * HOLD_MS_UNIT;
	// hold time in ms per code
	function automatic logic [9:0] hold_ms(input logic [2:0] code);
		case (code)
			3'h0: hold_ms = 10'd0;
			3'h1: hold_ms = 10'd10;
			3'h2: hold_ms = 10'd25;
			3'h3: hold_ms = 10'd50;
			3'h4: hold_ms = 10'd100;
			3'h5: hold_ms = 10'd250;
			3'h6: hold_ms = 10'd500;
			default: hold_ms = 10'd1000;
		endcase
	endfunction
endpackage

// *** core/ms_ticker.sv ***
// free-running millisecond tick generator
`timescale 1ns/1ps
`default_nettype none
module ms_ticker import config_regs_pkg::*; #(
	parameter int CYCLES = CYCLES_PER_MS
) (
	input wire logic clock,
	input wire logic rst_n,
	output logic tick
);
	// a period under two cycles would leave the tick stuck high
	if (CYCLES < 2) begin : g_bad_cycles
		$error("ms_ticker: CYCLES must be at least 2");
	end
	logic [31:0] count;
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			count <= 32'h0;
			tick <= 1'b0;
		end else if (count == 32'(CYCLES - 1)) begin
			count <= 32'h0;
			tick <= 1'b1;
		end else begin
			count <= count + 32'h1;
			tick <= 1'b0;
		end
	end
endmodule // ms_ticker
`default_nettype wire

// *** core/attack_pacer.sv ***
// brownout attack pacing: one step strobe every 2^rate samples
`timescale 1ns/1ps
`default_nettype none
module attack_pacer (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic active,
	input wire logic sample_tick,
	input wire logic [2:0] rate,
	output logic step
);
	logic [6:0] count;
	always_ff @(posedge clock) begin
		if (!rst_n || !active) begin
			count <= 7'h0;
			step <= 1'b0;
		end else if (sample_tick) begin
			// wraps at 2^rate samples
			if (count >= 7'((8'h1 << rate) - 8'h1)) begin
				count <= 7'h0;
				step <= 1'b1;
			end else begin
				count <= count + 7'h1;
				step <= 1'b0;
			end
		end else begin
			step <= 1'b0;
		end
	end
endmodule // attack_pacer
`default_nettype wire

// *** core/brownout_noise_gate_config_regs.sv ***
// register bank for brownout, noise gate, supply switching, pull-downs and masks
// Notes on behaviour
// - attack rate bits 7:5 give one attenuation step every 2^n samples, reset code 1.
// - attack step bits 4:3 pick 0.5/1/1.5/2 dB per step, reset 1 dB.
// - hold bits 2:0 pick 0..1000 ms of hold before release, reset code 6.
// - low supply-switch threshold bits 2:1 apply in supply-switch mode 3, reset code 3.
// - gate entry timer bits 7:5 set the below-threshold time before the gate engages, reset code 5.
// - gate level bits 4:3 set -90..-120 dBFS, reset code 3, and gate enable bit 2 resets on.
// - gate volume ramp bit 5 is inverted: zero ramps, one does not, reset one.
// - hysteresis bits 3:0 use codes A..F, 0..9 reserved, reset D, scaled below 48 ksps.
// - detect mode bit 7 picks fixed (0) or low-supply-relative (1) threshold, reset one.
// - supply-switch threshold bits 4:0 apply in mode 0, 0.25 dB per code, reset 08.
// - pull-down bits 6..2 drive link, data out, data in, frame sync and bit clock, reset off.
// - mute mask bit 7 and infinite-hold mask bit 6 mask when one, both reset one.
// - limiter mask bit 0 resets one, checksum mask bit 6 resets zero, one masks.
// - with infinite hold the attenuation stays until the self-clearing hold-clear bit is set.
`timescale 1ns/1ps
`default_nettype none
module brownout_noise_gate_config_regs import config_regs_pkg::*; #(
	parameter int CYCLES_MS = CYCLES_PER_MS
) (
	input wire logic clock,
	input wire logic rst_n,
	// control port
	input wire logic write_strobe,
	input wire logic read_strobe,
	input wire logic [7:0] address,
	input wire logic [7:0] write_data,
	output logic [7:0] read_data,
	output logic read_valid,
	// audio side
	input wire logic sample_tick,
	input wire logic brownout_event,
	input wire logic [1:0] supply_switch_mode,
	input wire logic mute_event,
	input wire logic inf_hold_event,
	input wire logic checksum_event,
	input wire logic limiter_event,
	output logic brownout_attack_step_strobe,
	output logic [1:0] brownout_attack_step,
	output logic brownout_attenuating,
	output logic [2:0] gate_entry_timer,
	output logic [1:0] gate_level,
	output logic gate_enable,
	output logic gate_volume_ramp_enable,
	output logic [3:0] supply_switch_hysteresis,
	output logic supply_switch_detect_mode,
	output logic [4:0] supply_switch_threshold,
	output logic [1:0] supply_switch_low_threshold,
	output logic [4:0] pin_pulldown_enable,
	output logic interrupt_request
);
	// ----------------------------------------------------------------
	// parameter checks
	// ----------------------------------------------------------------
	// the ms tick needs a period of two cycles or more
	if (CYCLES_MS < 2) begin : g_bad_cycles_ms
		$error("brownout_noise_gate_config_regs: CYCLES_MS must be at least 2");
	end

	// ----------------------------------------------------------------
	// register storage
	// ----------------------------------------------------------------
	logic [7:0] reg_attack_hold;
	logic [7:0] reg_low_threshold;
	logic [7:0] reg_gate_control;
	logic [7:0] reg_ramp_hysteresis;
	logic [7:0] reg_switch_threshold;
	logic [7:0] reg_pulldown;
	logic [7:0] reg_mask_brownout;
	logic [7:0] reg_mask_checksum;
	logic [7:0] reg_brownout_control;

	// merge write data into writable bits only
	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] data, input logic [7:0] wmask);
		merge = (old & ~wmask) | (data & wmask);
	endfunction

	function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
		hit = (a == target);
	endfunction

	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			reg_attack_hold <= RST_BROWNOUT_ATTACK_HOLD;
			reg_low_threshold <= RST_SUPPLY_SWITCH_LOW_THRESHOLD;
			reg_gate_control <= RST_NOISE_GATE_CONTROL;
			reg_ramp_hysteresis <= RST_NOISE_GATE_RAMP_SWITCH_HYSTERESIS;
			reg_switch_threshold <= RST_SUPPLY_SWITCH_THRESHOLD;
			reg_pulldown <= RST_PIN_PULLDOWN_ENABLES;
			reg_mask_brownout <= RST_INTERRUPT_MASK_BROWNOUT;
			reg_mask_checksum <= RST_INTERRUPT_MASK_CHECKSUM_LIMITER;
			reg_brownout_control <= RST_BROWNOUT_CONTROL;
		end else begin
			// hold-clear lasts a single cycle
			reg_brownout_control[HOLD_CLEAR_BIT] <= 1'b0;
			if (write_strobe) begin
				if (hit(address, ADDR_BROWNOUT_ATTACK_HOLD)) begin
					reg_attack_hold <= merge(reg_attack_hold, write_data, WMASK_BROWNOUT_ATTACK_HOLD);
				end else if (hit(address, ADDR_SUPPLY_SWITCH_LOW_THRESHOLD)) begin
					reg_low_threshold <= merge(reg_low_threshold, write_data, WMASK_SUPPLY_SWITCH_LOW_THRESHOLD);
				end else if (hit(address, ADDR_NOISE_GATE_CONTROL)) begin
					reg_gate_control <= merge(reg_gate_control, write_data, WMASK_NOISE_GATE_CONTROL);
				end else if (hit(address, ADDR_NOISE_GATE_RAMP_SWITCH_HYSTERESIS)) begin
					// reserved hysteresis codes are ignored so the switch timer stays valid
					if (write_data[HYSTERESIS_LSB +: 4] >= HYSTERESIS_FIRST_VALID) begin
						reg_ramp_hysteresis <= merge(reg_ramp_hysteresis, write_data,
							WMASK_NOISE_GATE_RAMP_SWITCH_HYSTERESIS);
					end else begin
						reg_ramp_hysteresis <= merge(reg_ramp_hysteresis, write_data,
							WMASK_NOISE_GATE_RAMP_SWITCH_HYSTERESIS & 8'hF0);
					end
				end else if (hit(address, ADDR_SUPPLY_SWITCH_THRESHOLD)) begin
					reg_switch_threshold <= merge(reg_switch_threshold, write_data, WMASK_SUPPLY_SWITCH_THRESHOLD);
				end else if (hit(address, ADDR_PIN_PULLDOWN_ENABLES)) begin
					reg_pulldown <= merge(reg_pulldown, write_data, WMASK_PIN_PULLDOWN_ENABLES);
				end else if (hit(address, ADDR_INTERRUPT_MASK_BROWNOUT)) begin
					reg_mask_brownout <= merge(reg_mask_brownout, write_data, WMASK_INTERRUPT_MASK_BROWNOUT);
				end else if (hit(address, ADDR_INTERRUPT_MASK_CHECKSUM_LIMITER)) begin
					reg_mask_checksum <= merge(reg_mask_checksum, write_data, WMASK_INTERRUPT_MASK_CHECKSUM_LIMITER);
				end else if (hit(address, ADDR_BROWNOUT_CONTROL)) begin
					// a hold-clear write wins over the self-clear above
					reg_brownout_control <= merge(reg_brownout_control, write_data, WMASK_BROWNOUT_CONTROL);
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// register reads
	// ----------------------------------------------------------------
	// unmapped offsets read zero so probing the map is harmless
	logic [7:0] next_read_data;
	always_comb begin
		if (hit(address, ADDR_BROWNOUT_ATTACK_HOLD)) begin
			next_read_data = reg_attack_hold;
		end else if (hit(address, ADDR_SUPPLY_SWITCH_LOW_THRESHOLD)) begin
			next_read_data = reg_low_threshold;
		end else if (hit(address, ADDR_NOISE_GATE_CONTROL)) begin
			next_read_data = reg_gate_control;
		end else if (hit(address, ADDR_NOISE_GATE_RAMP_SWITCH_HYSTERESIS)) begin
			next_read_data = reg_ramp_hysteresis;
		end else if (hit(address, ADDR_SUPPLY_SWITCH_THRESHOLD)) begin
			next_read_data = reg_switch_threshold;
		end else if (hit(address, ADDR_PIN_PULLDOWN_ENABLES)) begin
			next_read_data = reg_pulldown;
		end else if (hit(address, ADDR_INTERRUPT_MASK_BROWNOUT)) begin
			next_read_data = reg_mask_brownout;
		end else if (hit(address, ADDR_INTERRUPT_MASK_CHECKSUM_LIMITER)) begin
			next_read_data = reg_mask_checksum;
		end else if (hit(address, ADDR_BROWNOUT_CONTROL)) begin
			next_read_data = {reg_brownout_control[7:1], 1'b0};
		end else begin
			next_read_data = 8'h00;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			read_data <= 8'h00;
			read_valid <= 1'b0;
		end else begin
			read_valid <= read_strobe;
			if (read_strobe) begin
				read_data <= next_read_data;
			end
		end
	end

	// ----------------------------------------------------------------
	// brownout attenuation and hold
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		BO_IDLE = 3'b001,
		BO_ATTACK = 3'b010,
		BO_HOLD = 3'b100
	} brownout_state_t;

	brownout_state_t state;
	logic ms_tick;
	logic pacer_step;
	logic [9:0] hold_count;
	logic inf_hold;
	logic hold_clear;

	assign inf_hold = reg_brownout_control[INF_HOLD_BIT];
	assign hold_clear = reg_brownout_control[HOLD_CLEAR_BIT];

	ms_ticker #(.CYCLES(CYCLES_MS)) ticker (
		.clock(clock),
		.rst_n(rst_n),
		.tick(ms_tick)
	);

	// the pacer restarts on every attack entry, so the first step waits a full period
	attack_pacer pacer (
		.clock(clock),
		.rst_n(rst_n),
		.active(state == BO_ATTACK),
		.sample_tick(sample_tick),
		.rate(reg_attack_hold[ATTACK_RATE_LSB +: 3]),
		.step(pacer_step)
	);

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state <= BO_IDLE;
			hold_count <= 10'h0;
		end else begin
			case (state)
				BO_IDLE: begin
					if (brownout_event) begin
						state <= BO_ATTACK;
					end
				end
				BO_ATTACK: begin
					// attenuation keeps stepping while the event persists
					if (!brownout_event) begin
						state <= BO_HOLD;
						hold_count <= 10'h0;
					end
				end
				BO_HOLD: begin
					if (brownout_event) begin
						state <= BO_ATTACK;
					end else if (inf_hold) begin
						if (hold_clear) begin
							state <= BO_IDLE;
						end
					// the ms tick runs free, so one extra tick keeps a nonzero hold from ending early
					end else if (hold_ms(reg_attack_hold[HOLD_TIME_LSB +: 3]) == 10'd0
						|| hold_count > hold_ms(reg_attack_hold[HOLD_TIME_LSB +: 3])) begin
						state <= BO_IDLE;
					end else if (ms_tick) begin
						hold_count <= hold_count + 10'h1;
					end
				end
				default: begin
					state <= BO_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			brownout_attack_step_strobe <= 1'b0;
			brownout_attack_step <= RST_BROWNOUT_ATTACK_HOLD[ATTACK_STEP_LSB +: 2];
			brownout_attenuating <= 1'b0;
		end else begin
			brownout_attack_step_strobe <= pacer_step;
			brownout_attack_step <= reg_attack_hold[ATTACK_STEP_LSB +: 2];
			// covers the hold too, so the gain stays put until release
			brownout_attenuating <= (state != BO_IDLE);
		end
	end

	// ----------------------------------------------------------------
	// configuration outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			gate_entry_timer <= RST_NOISE_GATE_CONTROL[GATE_TIMER_LSB +: 3];
			gate_level <= RST_NOISE_GATE_CONTROL[GATE_LEVEL_LSB +: 2];
			gate_enable <= RST_NOISE_GATE_CONTROL[GATE_ENABLE_BIT];
			gate_volume_ramp_enable <= ~RST_NOISE_GATE_RAMP_SWITCH_HYSTERESIS[GATE_RAMP_BIT];
			supply_switch_hysteresis <= RST_NOISE_GATE_RAMP_SWITCH_HYSTERESIS[HYSTERESIS_LSB +: 4];
			supply_switch_detect_mode <= RST_SUPPLY_SWITCH_THRESHOLD[DETECT_MODE_BIT];
			supply_switch_threshold <= RST_SUPPLY_SWITCH_THRESHOLD[SWITCH_THRESHOLD_LSB +: 5];
			supply_switch_low_threshold <= RST_SUPPLY_SWITCH_LOW_THRESHOLD[LOW_THRESHOLD_LSB +: 2];
			pin_pulldown_enable <= RST_PIN_PULLDOWN_ENABLES[PULLDOWN_LSB +: 5];
		end else begin
			gate_entry_timer <= reg_gate_control[GATE_TIMER_LSB +: 3];
			gate_level <= reg_gate_control[GATE_LEVEL_LSB +: 2];
			gate_enable <= reg_gate_control[GATE_ENABLE_BIT];
			// inverted sense: stored one means no ramping
			gate_volume_ramp_enable <= ~reg_ramp_hysteresis[GATE_RAMP_BIT];
			supply_switch_hysteresis <= reg_ramp_hysteresis[HYSTERESIS_LSB +: 4];
			supply_switch_detect_mode <= reg_switch_threshold[DETECT_MODE_BIT];
			supply_switch_threshold <= reg_switch_threshold[SWITCH_THRESHOLD_LSB +: 5];
			supply_switch_low_threshold <= reg_low_threshold[LOW_THRESHOLD_LSB +: 2];
			pin_pulldown_enable <= reg_pulldown[PULLDOWN_LSB +: 5];
		end
	end

	// ----------------------------------------------------------------
	// interrupt gating
	// ----------------------------------------------------------------
	// events are level inputs; latching lives in the flag registers elsewhere
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			interrupt_request <= 1'b0;
		end else begin
			interrupt_request <= (mute_event & ~reg_mask_brownout[MASK_MUTE_BIT])
				| (inf_hold_event & ~reg_mask_brownout[MASK_INF_HOLD_BIT])
				| (checksum_event & ~reg_mask_checksum[MASK_CHECKSUM_BIT])
				| (limiter_event & ~reg_mask_checksum[MASK_LIMITER_BIT]);
		end
	end

endmodule // brownout_noise_gate_config_regs
`default_nettype wire

// *** sim/config_regs_asserts.sv ***
// checker for the brownout / noise gate register bank ports
`timescale 1ns/1ps
`default_nettype none
module config_regs_asserts (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic write_strobe,
	input wire logic read_strobe,
	input wire logic [7:0] address,
	input wire logic [7:0] write_data,
	input wire logic [7:0] read_data,
	input wire logic read_valid,
	input wire logic mute_event,
	input wire logic inf_hold_event,
	input wire logic checksum_event,
	input wire logic limiter_event,
	input wire logic [1:0] gate_level,
	input wire logic gate_volume_ramp_enable,
	input wire logic [3:0] supply_switch_hysteresis,
	input wire logic [4:0] supply_switch_threshold,
	input wire logic [4:0] pin_pulldown_enable,
	input wire logic interrupt_request
);
	// ----------------------------------------------------------------
	// sequences
	// ----------------------------------------------------------------
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	sequence wr(logic [7:0] a);
		write_strobe && address == a;
	endsequence
	sequence rd_unmapped;
		read_strobe && !(address inside {8'h1F, 8'h20, [8'h34:8'h38], 8'h3B, 8'h3C});
	endsequence
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	read_answer_a: assert property (read_strobe |=> read_valid) else $error("read not answered");
	read_quiet_a: assert property (!read_strobe |=> !read_valid) else $error("stray read valid");
	unmapped_zero_a: assert property (rd_unmapped |=> read_data == 8'h00) else $error("unmapped read not zero");
	ramp_inverse_a: assert property (
		wr(8'h36) |-> ##2 gate_volume_ramp_enable == !$past(write_data[5], 2))
		else $error("ramp enable not inverse of bit 5");
	hyst_refuse_a: assert property (
		(wr(8'h36) ##0 write_data[3:0] < 4'hA) |=> ##1 $stable(supply_switch_hysteresis))
		else $error("reserved hysteresis code taken");
	pulldown_copy_a: assert property (
		wr(8'h38) |-> ##2 pin_pulldown_enable == $past(write_data[6:2], 2))
		else $error("pull-down enables wrong");
	gate_level_a: assert property (
		wr(8'h35) |-> ##2 gate_level == $past(write_data[4:3], 2))
		else $error("gate level wrong");
	switch_thresh_a: assert property (
		wr(8'h37) |-> ##2 supply_switch_threshold == $past(write_data[4:0], 2))
		else $error("switch threshold wrong");
	irq_quiet_a: assert property (
		!(mute_event || inf_hold_event || checksum_event || limiter_event) |=> !interrupt_request)
		else $error("interrupt without source");
	reset_fields_a: assert property (
		$rose(rst_n) |-> gate_level == 2'h3 && supply_switch_hysteresis == 4'hD
		&& supply_switch_threshold == 5'h08 && !gate_volume_ramp_enable) else $error("reset fields wrong");
endmodule // config_regs_asserts

bind brownout_noise_gate_config_regs config_regs_asserts chk (.*);
`default_nettype wire

// *** sim/brownout_noise_gate_config_regs_tb_top.sv ***
// self-checking bench for the brownout / noise gate register bank
`timescale 1ns/1ps
`default_nettype none
module brownout_noise_gate_config_regs_tb_top import config_regs_pkg::*;;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic write_strobe = 1'b0, read_strobe = 1'b0, sample_tick = 1'b0, brownout_event = 1'b0;
	logic mute_event = 1'b0, inf_hold_event = 1'b0, checksum_event = 1'b0, limiter_event = 1'b0;
	logic [7:0] address = 8'h00, write_data = 8'h00, read_data;
	logic [1:0] supply_switch_mode = 2'h0;
	logic read_valid, brownout_attack_step_strobe, brownout_attenuating, gate_enable, gate_volume_ramp_enable;
	logic supply_switch_detect_mode, interrupt_request;
	logic [1:0] brownout_attack_step, gate_level, supply_switch_low_threshold;
	logic [2:0] gate_entry_timer;
	logic [3:0] supply_switch_hysteresis;
	logic [4:0] supply_switch_threshold, pin_pulldown_enable;
	logic [25:0] fields;
	int fail_count = 0, tests_run = 0, cycles = 0, steps;
	logic [7:0] addr_tab [8] = '{8'h20, 8'h34, 8'h35, 8'h36, 8'h37, 8'h38, 8'h3B, 8'h3C};
	logic [7:0] rst_tab [8] = '{8'h2E, 8'h06, 8'hBD, 8'hAD, 8'hA8, 8'h00, 8'hFC, 8'hBB};
	logic [7:0] wm_tab [8] = '{8'hFF, 8'h06, 8'hFC, 8'hEF, 8'h9F, 8'h7C, 8'hC0, 8'h41};

	// short ms count keeps the hold checks to a few hundred cycles
	brownout_noise_gate_config_regs #(.CYCLES_MS(10)) uut (.*);

	assign fields = {gate_entry_timer, gate_level, gate_enable, gate_volume_ramp_enable, supply_switch_hysteresis,
		supply_switch_detect_mode, supply_switch_threshold, supply_switch_low_threshold, pin_pulldown_enable,
		brownout_attack_step};

	always #10 clock = ~clock;

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic close_out();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic check(input string name, input logic [25:0] seen, input logic [25:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		address <= a;
		write_data <= d;
		write_strobe <= 1'b1;
		@(posedge clock);
		write_strobe <= 1'b0;
	endtask
	task automatic rd_check(input string name, input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock);
		address <= a;
		read_strobe <= 1'b1;
		@(posedge clock);
		read_strobe <= 1'b0;
		#1;
		check("read valid", 26'(read_valid), 26'h1);
		check(name, 26'(read_data), 26'(exp));
	endtask
	// sources are levels: raise one set, look two edges on, then drop
	task automatic irq_try(input logic [3:0] src, input logic exp);
		@(posedge clock);
		{mute_event, inf_hold_event, checksum_event, limiter_event} <= src;
		repeat (2) @(posedge clock);
		#1;
		check("interrupt", 26'(interrupt_request), 26'(exp));
		@(posedge clock);
		{mute_event, inf_hold_event, checksum_event, limiter_event} <= 4'h0;
		repeat (2) @(posedge clock);
	endtask
	task automatic hold_for(input int n, input logic exp);
		repeat (n) @(posedge clock);
		#1;
		check("attenuating", 26'(brownout_attenuating), 26'(exp));
	endtask

	// ----------------------------------------------------------------
	// sequence of tests
	// ----------------------------------------------------------------
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			close_out();
		end
	end

	initial begin
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		repeat (2) @(posedge clock);
		#1;
		check("reset fields", fields,
			{3'h5, 2'h3, 1'h1, 1'h0, 4'hD, 1'h1, 5'h08, 2'h3, 5'h00, 2'h1});
		for (int i = 0; i < 8; i++)
			rd_check("reset value", addr_tab[i], rst_tab[i]);
		irq_try(4'b0010, 1'b1);
		irq_try(4'b0001, 1'b0);
		irq_try(4'b1000, 1'b0);
		irq_try(4'b0100, 1'b0);
		for (int i = 0; i < 8; i++) begin
			wr(addr_tab[i], 8'hFF);
			rd_check("ones", addr_tab[i], (rst_tab[i] & ~wm_tab[i]) | wm_tab[i]);
		end
		check("ones fields", fields,
			{3'h7, 2'h3, 1'h1, 1'h0, 4'hF, 1'h1, 5'h1F, 2'h3, 5'h1F, 2'h3});
		irq_try(4'b0010, 1'b0);
		// zero hysteresis code is reserved, so that field keeps F
		for (int i = 0; i < 8; i++) begin
			wr(addr_tab[i], 8'h00);
			rd_check("zeros", addr_tab[i],
				(rst_tab[i] & ~wm_tab[i]) | (i == 3 ? 8'h0F : 8'h00));
		end
		check("zero fields", fields,
			{3'h0, 2'h0, 1'h0, 1'h1, 4'hF, 1'h0, 5'h00, 2'h0, 5'h00, 2'h0});
		irq_try(4'b1000, 1'b1);
		irq_try(4'b0100, 1'b1);
		irq_try(4'b0001, 1'b1);
		wr(8'h21, 8'hFF);
		rd_check("unmapped", 8'h21, 8'h00);
		// rate 2, step 1.5 dB, hold 10 ms; a sample on every cycle
		wr(8'h20, 8'h51);
		@(posedge clock);
		sample_tick <= 1'b1;
		supply_switch_mode <= 2'h3;
		brownout_event <= 1'b1;
		repeat (8) @(posedge clock);
		steps = 0;
		repeat (32) begin
			@(posedge clock);
			#1;
			if (brownout_attack_step_strobe === 1'b1)
				steps++;
		end
		check("attack steps", 26'(steps), 26'd8);
		check("step size", 26'(brownout_attack_step), 26'h2);
		@(posedge clock);
		brownout_event <= 1'b0;
		hold_for(80, 1'b1);
		hold_for(40, 1'b0);
		wr(8'h1F, 8'h02);
		@(posedge clock);
		brownout_event <= 1'b1;
		repeat (10) @(posedge clock);
		brownout_event <= 1'b0;
		hold_for(150, 1'b1);
		rd_check("infinite hold", 8'h1F, 8'h02);
		wr(8'h1F, 8'h03);
		hold_for(4, 1'b0);
		rd_check("hold clear", 8'h1F, 8'h02);
		close_out();
	end
endmodule // brownout_noise_gate_config_regs_tb_top
`default_nettype wire
